// File: hw/sbf_params.svh
`ifndef SBF_PARAMS_SVH
`define SBF_PARAMS_SVH

// Fixed device type identifier carried in select byte bits 7..4 (value is arbitrary).
`define SBF_TYPE_ID 4'h5
// Select byte field positions.
`define SBF_TYPE_HI 7
`define SBF_TYPE_LO 4
`define SBF_CS_HI 3
`define SBF_CS_LO 1
`define SBF_DIR_BIT 0
// Direction bit value that requests a read.
`define SBF_DIR_READ 1'h1
// Bits per byte and the bit count of the acknowledge slot.
`define SBF_BYTE_BITS 4'h8
`define SBF_ACK_SLOT 4'h8
// Address bytes that follow a write select byte.
`define SBF_ADDR_BYTES 2'h2
// Largest number of data bytes taken in one write.
`define SBF_PAGE_BYTES 6'h20

`endif

// File: hw/sbf_pkg.sv
package sbf_pkg;

   // Protocol states of the bus front end.
   typedef enum logic [2:0] {
      SBF_IDLE = 3'b000,
      SBF_SEL = 3'b001,
      SBF_ADDR = 3'b010,
      SBF_WDATA = 3'b011,
      SBF_RDATA = 3'b100,
      SBF_WBUSY = 3'b101
   } sbf_state_e;

   // Conditions found on the synchronised bus lines in one cycle.
   typedef struct packed {
      logic start;
      logic stop;
      logic rise;
      logic fall;
      logic sda;
   } sbf_bus_ev_s;

   // Data byte handed to the memory core.
   typedef struct packed {
      logic valid;
      logic [7:0] data;
   } sbf_byte_s;

endpackage

// File: hw/sbf_line_sync.sv
`timescale 1ns/10ps
`default_nettype none

// Two-stage synchroniser and condition finder for the bus lines.
module sbf_line_sync (
   // Clock and reset.
   input wire logic sys_clk,
   input wire logic reset,
   // Raw bus lines.
   input wire logic scl_in,
   input wire logic sda_in,
   // Conditions found.
   output sbf_pkg::sbf_bus_ev_s ev
);

   logic [1:0] scl_meta_ff;
   logic [1:0] sda_meta_ff;
   logic scl_q_ff;
   logic sda_q_ff;

   // ***********************************
   // Synchronisers
   // ***********************************
   // Idle lines are high, so the chain resets high to avoid a false start.
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         scl_meta_ff <= 2'h3;
         sda_meta_ff <= 2'h3;
         scl_q_ff <= 1'h1;
         sda_q_ff <= 1'h1;
      end else begin
         scl_meta_ff <= {scl_meta_ff[0], scl_in};
         sda_meta_ff <= {sda_meta_ff[0], sda_in};
         scl_q_ff <= scl_meta_ff[1];
         sda_q_ff <= sda_meta_ff[1];
      end
   end

   // ***********************************
   // Edge and condition detection
   // ***********************************
   // Start and stop are data edges while the clock stays high.
   always_comb begin
      ev.start = scl_q_ff && scl_meta_ff[1] && sda_q_ff && !sda_meta_ff[1];
      ev.stop = scl_q_ff && scl_meta_ff[1] && !sda_q_ff && sda_meta_ff[1];
      ev.rise = !scl_q_ff && scl_meta_ff[1];
      ev.fall = scl_q_ff && !scl_meta_ff[1];
      ev.sda = sda_meta_ff[1];
   end

endmodule

`default_nettype wire

// File: hw/sbf_shifter.sv
`include "sbf_params.svh"
`timescale 1ns/10ps
`default_nettype none

// Bit counter and shift register, capturing on bus clock rising edges.
module sbf_shifter (
   // Clock and reset.
   input wire logic sys_clk,
   input wire logic reset,
   // Control.
   input wire logic clear,
   input wire logic rise,
   input wire logic sda,
   input wire logic fall,
   // State.
   output logic [3:0] bit_cnt,
   output logic [7:0] shift
);

   logic rise_seen_ff;

   // ***********************************
   // Counting and capture
   // ***********************************
   // Counts 0..8; the ninth clock is the acknowledge slot, then wraps to 0.
   // Only a fall that closes a clocked bit counts, so the fall ending a start is skipped.
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         bit_cnt <= 4'h0;
         shift <= 8'h00;
         rise_seen_ff <= 1'h0;
      end else if (clear) begin
         bit_cnt <= 4'h0;
         rise_seen_ff <= 1'h0;
      end else begin
         if (rise) begin
            rise_seen_ff <= 1'h1;
         end
         if (rise && bit_cnt < `SBF_BYTE_BITS) begin
            shift <= {shift[6:0], sda};
         end
         if (fall && rise_seen_ff) begin
            bit_cnt <= (bit_cnt == `SBF_ACK_SLOT) ? 4'h0 : bit_cnt + 4'h1;
            rise_seen_ff <= 1'h0;
         end
      end
   end

endmodule

`default_nettype wire

// File: hw/sbf_front_end.sv
// Behaviour
// - Write protect high blocks all array writes.
// - Write protect low or open allows writes.
// - Protected: ack select, address; not data.
// - After reset, idle in standby; ignore bus.
// - Slave only; never drives bus clock.
// - Start is data fall, clock high.
// - Watch for starts except during write cycle.
// - Stop is data rise, clock high; end.
// - Read NoAck then stop returns standby.
// - Stop after write data starts write cycle.
// - Release data after eight bits; ninth acks.
// - Capture data on bus clock rising edge.
// - Select byte: type, chip select, direction.
// - Wrong type field gets no acknowledge.
// - Chip select field must equal pins.
// - Direction bit: one reads, zero writes.
// - Match acks ninth slot; mismatch goes standby.
// - Sequential reads ignore write protect.
// - Page write up to 32 bytes.
// - Data line driven only low.
`include "sbf_params.svh"
`timescale 1ns/10ps
`default_nettype none

module sbf_front_end (
   // Clock and reset.
   input wire logic sys_clk,
   input wire logic reset,
   // Bus lines from the master; the bus clock is input only.
   input wire logic scl_in,
   input wire logic sda_in,
   // Open-drain data line drive.
   output logic sda_out,
   output logic sda_oe,
   // Configuration pins.
   input wire logic write_protect_input,
   input wire logic chip_select_pin_2,
   input wire logic chip_select_pin_1,
   input wire logic chip_select_pin_0,
   // Memory core side.
   input wire logic [7:0] rd_data,
   input wire logic write_done,
   output logic [15:0] addr_out,
   output sbf_pkg::sbf_byte_s wr_byte,
   output logic rd_next,
   output logic write_start,
   output logic busy,
   output logic standby
);

   sbf_pkg::sbf_bus_ev_s ev;
   sbf_pkg::sbf_state_e state_ff;
   sbf_pkg::sbf_state_e nxt_state;
   logic [3:0] bit_cnt;
   logic [7:0] shift;
   logic [2:0] pins_meta_ff;
   logic [2:0] pins_ff;
   logic [1:0] wp_meta_ff;
   logic wp_ff;
   logic [1:0] addr_cnt_ff;
   logic [5:0] data_cnt_ff;
   logic [7:0] tx_ff;
   logic ack_ff;
   logic [7:0] addr_hi_ff;
   logic clear;
   logic byte_end;
   logic sel_match;

   // ***********************************
   // Pin synchronisers and submodules
   // ***********************************
   // Open write protect reads low because the pad pulls it down externally.
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         pins_meta_ff <= 3'h0;
         pins_ff <= 3'h0;
         wp_meta_ff <= 2'h0;
         wp_ff <= 1'h0;
      end else begin
         pins_meta_ff <= {chip_select_pin_2, chip_select_pin_1, chip_select_pin_0};
         pins_ff <= pins_meta_ff;
         wp_meta_ff <= {wp_meta_ff[0], write_protect_input};
         wp_ff <= wp_meta_ff[1];
      end
   end

   sbf_line_sync u_sync (
      .sys_clk(sys_clk),
      .reset(reset),
      .scl_in(scl_in),
      .sda_in(sda_in),
      .ev(ev)
   );

   // A start restarts byte framing; ignored while the write cycle runs.
   assign clear = (ev.start && state_ff != sbf_pkg::SBF_WBUSY) || ev.stop;

   sbf_shifter u_shift (
      .sys_clk(sys_clk),
      .reset(reset),
      .clear(clear),
      .rise(ev.rise),
      .sda(ev.sda),
      .fall(ev.fall),
      .bit_cnt(bit_cnt),
      .shift(shift)
   );

   // The eighth bit has been taken when the clock falls after it.
   assign byte_end = ev.fall && bit_cnt == `SBF_BYTE_BITS - 4'h1;
   assign sel_match = shift[`SBF_TYPE_HI:`SBF_TYPE_LO] == `SBF_TYPE_ID
      && shift[`SBF_CS_HI:`SBF_CS_LO] == pins_ff;

   // ***********************************
   // Protocol state machine
   // ***********************************
   always_comb begin
      nxt_state = state_ff;
      unique case (state_ff)
         sbf_pkg::SBF_IDLE: begin
            if (ev.start) begin
               nxt_state = sbf_pkg::SBF_SEL;
            end
         end
         sbf_pkg::SBF_SEL: begin
            if (byte_end) begin
               if (!sel_match) begin
                  nxt_state = sbf_pkg::SBF_IDLE;
               end else if (shift[`SBF_DIR_BIT] == `SBF_DIR_READ) begin
                  nxt_state = sbf_pkg::SBF_RDATA;
               end else begin
                  nxt_state = sbf_pkg::SBF_ADDR;
               end
            end
         end
         sbf_pkg::SBF_ADDR: begin
            if (byte_end && addr_cnt_ff == `SBF_ADDR_BYTES - 2'h1) begin
               nxt_state = sbf_pkg::SBF_WDATA;
            end
         end
         sbf_pkg::SBF_WDATA: begin
         end
         sbf_pkg::SBF_RDATA: begin
            // A master NoAck in the ninth slot ends the read.
            if (ev.rise && bit_cnt == `SBF_ACK_SLOT && ev.sda) begin
               nxt_state = sbf_pkg::SBF_IDLE;
            end
         end
         sbf_pkg::SBF_WBUSY: begin
            if (write_done) begin
               nxt_state = sbf_pkg::SBF_IDLE;
            end
         end
         default: begin
            nxt_state = sbf_pkg::SBF_IDLE;
         end
      endcase
      if (state_ff != sbf_pkg::SBF_WBUSY) begin
         if (ev.stop) begin
            // Stop after accepted data launches the write; else standby.
            nxt_state = (state_ff == sbf_pkg::SBF_WDATA && data_cnt_ff != 6'h00
               && bit_cnt == 4'h0) ? sbf_pkg::SBF_WBUSY : sbf_pkg::SBF_IDLE;
         end else if (ev.start) begin
            nxt_state = sbf_pkg::SBF_SEL;
         end
      end
   end

   // Reset lands in standby with every counter cleared.
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         state_ff <= sbf_pkg::SBF_IDLE;
      end else begin
         state_ff <= nxt_state;
      end
   end

   // ***********************************
   // Address and data counters
   // ***********************************
   // Address bytes arrive high byte first; data count holds the page limit.
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         addr_cnt_ff <= 2'h0;
         data_cnt_ff <= 6'h00;
         addr_hi_ff <= 8'h00;
         addr_out <= 16'h0000;
      end else if (clear) begin
         addr_cnt_ff <= 2'h0;
         data_cnt_ff <= 6'h00;
      end else if (byte_end) begin
         if (state_ff == sbf_pkg::SBF_ADDR) begin
            addr_cnt_ff <= addr_cnt_ff + 2'h1;
            if (addr_cnt_ff == 2'h0) begin
               addr_hi_ff <= shift;
            end else begin
               addr_out <= {addr_hi_ff, shift};
            end
         end else if (state_ff == sbf_pkg::SBF_WDATA && !wp_ff
            && data_cnt_ff != `SBF_PAGE_BYTES) begin
            data_cnt_ff <= data_cnt_ff + 6'h01;
         end
      end
   end

   // ***********************************
   // Memory core strobes
   // ***********************************
   // Data bytes reach the core only when writes are allowed.
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         wr_byte <= '0;
         rd_next <= 1'h0;
         write_start <= 1'h0;
      end else begin
         wr_byte.valid <= byte_end && state_ff == sbf_pkg::SBF_WDATA && !wp_ff
            && data_cnt_ff != `SBF_PAGE_BYTES;
         wr_byte.data <= shift;
         // Own ack of the select byte is not a master ack, hence the ack_ff term.
         rd_next <= ev.rise && state_ff == sbf_pkg::SBF_RDATA
            && bit_cnt == `SBF_ACK_SLOT && !ev.sda && !ack_ff;
         write_start <= state_ff != sbf_pkg::SBF_WBUSY
            && nxt_state == sbf_pkg::SBF_WBUSY;
      end
   end

   // Status outputs are registered from the next state, so they change in the same cycle as the state register.
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         busy <= 1'h0;
         standby <= 1'h1;
      end else begin
         busy <= nxt_state == sbf_pkg::SBF_WBUSY;
         standby <= nxt_state == sbf_pkg::SBF_IDLE;
      end
   end

   // ***********************************
   // Acknowledge and read data drive
   // ***********************************
   // Decide the ack at the end of each received byte; protected data is refused.
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         ack_ff <= 1'h0;
      end else if (clear) begin
         ack_ff <= 1'h0;
      end else if (byte_end) begin
         unique case (state_ff)
            sbf_pkg::SBF_SEL: ack_ff <= sel_match;
            sbf_pkg::SBF_ADDR: ack_ff <= 1'h1;
            sbf_pkg::SBF_WDATA: ack_ff <= !wp_ff && data_cnt_ff != `SBF_PAGE_BYTES;
            default: ack_ff <= 1'h0;
         endcase
      end else if (ev.fall && bit_cnt == `SBF_ACK_SLOT) begin
         ack_ff <= 1'h0;
      end
   end

   // Read byte is loaded at the end of the acknowledge slot, shifted out MSB first.
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         tx_ff <= 8'hFF;
      end else if (state_ff != sbf_pkg::SBF_RDATA) begin
         tx_ff <= rd_data;
      end else if (ev.fall && bit_cnt == `SBF_ACK_SLOT) begin
         tx_ff <= rd_data;
      end else if (ev.fall && bit_cnt < `SBF_BYTE_BITS - 4'h1) begin
         tx_ff <= {tx_ff[6:0], 1'h1};
      end
   end

   // The pin only ever pulls low; the bus clock is never driven at all.
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         sda_out <= 1'h0;
         sda_oe <= 1'h0;
      end else begin
         sda_out <= 1'h0;
         if (state_ff == sbf_pkg::SBF_RDATA && nxt_state == sbf_pkg::SBF_RDATA
            && bit_cnt < `SBF_BYTE_BITS) begin
            sda_oe <= !tx_ff[7];
         end else begin
            sda_oe <= ack_ff && nxt_state != sbf_pkg::SBF_IDLE;
         end
      end
   end

endmodule

`default_nettype wire

// File: tb/sbf_fe_checker.sv
`timescale 1ns/10ps
`default_nettype none
// ****************************************
// Pin-level checks on the front end
// ****************************************
module sbf_chk (
   // Clock and reset.
   input wire logic sys_clk,
   input wire logic reset,
   // Bus and pins.
   input wire logic scl_in,
   input wire logic sda_out,
   input wire logic sda_oe,
   input wire logic write_protect_input,
   // Core side.
   input wire logic write_done,
   input wire sbf_pkg::sbf_byte_s wr_byte,
   input wire logic rd_next,
   input wire logic write_start,
   input wire logic busy,
   input wire logic standby
);
   // One clock domain, so clock and reset are given once for all checks.
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (reset);
   a_out_low: assert property (sda_out == 1'h0)
      else $error("data line driven high");
   a_reset_idle: assert property ($fell(reset) |-> standby && !busy)
      else $error("not idle after reset");
   a_busy_quiet: assert property (busy |-> !sda_oe)
      else $error("drive during write cycle");
   a_protect_block: assert property (wr_byte.valid |-> !write_protect_input)
      else $error("byte passed while protected");
   a_launch_busy: assert property (write_start |=> busy && !write_start)
      else $error("write launch not followed by busy");
   a_busy_hold: assert property (busy && !write_done |=> busy)
      else $error("busy dropped early");
   // Drive changes only while the bus clock is low, so the master samples cleanly.
   a_ack_lowclk: assert property ($rose(sda_oe) |-> !scl_in)
      else $error("pull started with clock high");
   a_rel_lowclk: assert property ($fell(sda_oe) |-> !scl_in)
      else $error("release with clock high");
   a_idle_quiet: assert property (standby |-> !sda_oe)
      else $error("drive while in standby");
   a_next_pulse: assert property (rd_next |=> !rd_next)
      else $error("read advance longer than one cycle");
endmodule

bind sbf_front_end sbf_chk sbf_chk_i (
   .sys_clk, .reset, .scl_in, .sda_out, .sda_oe, .write_protect_input,
   .write_done, .wr_byte, .rd_next, .write_start, .busy, .standby
);
`default_nettype wire

// File: tb/sbf_mst.sv
`timescale 1ns/10ps
`default_nettype none
// ****************************************
// Bus master model, 125 ns bus clock
// ****************************************
module sbf_mst (
   // Lines driven by the master.
   output logic scl,
   output logic sda_drv,
   // Resolved data line.
   input wire logic sda_line
);
   localparam realtime QP = 31.25;
   // Idle bus: clock stands high, data released to the pull-up.
   initial begin
      scl = 1'h1;
      sda_drv = 1'h1;
   end
   // One bit slot; data changes only while the clock is low.
   task automatic bs(input logic d, output logic q);
      sda_drv = d;
      #QP scl = 1'h1;
      q = sda_line;
      #(2*QP) scl = 1'h0;
      #QP;
   endtask
   // Start, also usable as a repeated start from a low clock.
   task automatic st();
      sda_drv = 1'h1;
      #QP scl = 1'h1;
      #QP sda_drv = 1'h0;
      #QP scl = 1'h0;
      #QP;
   endtask
   // Stop, leaving the bus idle.
   task automatic sp();
      sda_drv = 1'h0;
      #QP scl = 1'h1;
      #QP sda_drv = 1'h1;
      #(2*QP);
   endtask
   // Write a byte MSB first, then release for the acknowledge slot.
   task automatic wb(input logic [7:0] b, output logic ack);
      logic q;
      for (int i = 7; i >= 0; i--) begin
         bs(b[i], q);
      end
      bs(1'h1, q);
      ack = !q;
   endtask
   // Read a byte, then acknowledge it or not.
   task automatic rb(input logic ack_it, output logic [7:0] b);
      logic q;
      for (int i = 7; i >= 0; i--) begin
         bs(1'h1, b[i]);
      end
      bs(!ack_it, q);
   endtask
endmodule
`default_nettype wire

// File: tb/tb_top.sv
`timescale 1ns/10ps
`default_nettype none
`include "sbf_params.svh"
// ****************************************
// Bench top
// ****************************************
module tb_top;
   logic sys_clk, reset, scl, sda_drv, sda_line, wp, write_done, a;
   logic [2:0] cs;
   logic [7:0] rd_data, b;
   logic sda_out, sda_oe, rd_next, write_start, busy, standby;
   logic [15:0] addr_out;
   sbf_pkg::sbf_byte_s wr_byte;
   int fail_count = 0;
   int checks_done = 0;
   int seed, t;
   int cyc = 0;
   int ws_cnt = 0;
   int rn_cnt = 0;
   logic [7:0] exp_q[$];
   // Pull-up wire: low whenever either party pulls it.
   assign sda_line = sda_drv & ~sda_oe;
   sbf_mst sbf_mst_i (.scl(scl), .sda_drv(sda_drv), .sda_line(sda_line));
   sbf_front_end sbf_front_end_i (
      .sys_clk(sys_clk), .reset(reset), .scl_in(scl), .sda_in(sda_line),
      .sda_out(sda_out), .sda_oe(sda_oe), .write_protect_input(wp),
      .chip_select_pin_2(cs[2]), .chip_select_pin_1(cs[1]), .chip_select_pin_0(cs[0]),
      .rd_data(rd_data), .write_done(write_done), .addr_out(addr_out),
      .wr_byte(wr_byte), .rd_next(rd_next), .write_start(write_start),
      .busy(busy), .standby(standby));
   // System clock, 100 MHz.
   initial begin
      sys_clk = 1'h0;
      forever #5 sys_clk = ~sys_clk;
   end
   task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
      checks_done++;
      if (got !== exp) begin
         fail_count++;
         $display("unexpected at %0t: %s got %0h want %0h", $time, what, got, exp);
      end
   endtask
   task automatic finish_test();
      $display("checks %0d mismatches %0d", checks_done, fail_count);
      if (fail_count == 0 && checks_done > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   // Conditions reach the core some cycles after the pins move.
   task automatic settle();
      repeat (8) @(negedge sys_clk);
   endtask
   task automatic sel(input logic rd);
      sbf_mst_i.st();
      sbf_mst_i.wb({`SBF_TYPE_ID, cs, rd}, a);
      check(a, 1'h1, "select ack");
   endtask
   // Write of n data bytes; with protection off the queue predicts each of the first 32 bytes.
   task automatic wr_txn(input int n, input logic prot);
      logic [15:0] ad;
      logic [7:0] d;
      int w, i;
      ad = 16'($random(seed));
      w = ws_cnt;
      sel(1'h0);
      sbf_mst_i.wb(ad[15:8], a);
      check(a, 1'h1, "addr ack");
      sbf_mst_i.wb(ad[7:0], a);
      check(a, 1'h1, "addr ack");
      check(addr_out, ad, "address");
      for (i = 0; i < n; i++) begin
         d = 8'($random(seed));
         if (!prot && i < 32) exp_q.push_back(d);
         sbf_mst_i.wb(d, a);
         check(a, !prot && i < 32, "data ack");
      end
      sbf_mst_i.sp();
      settle();
      check(ws_cnt - w, !prot, "write launch");
      check(exp_q.size(), 0, "bytes left");
      if (!prot) begin
         sbf_mst_i.st();
         sbf_mst_i.wb({`SBF_TYPE_ID, cs, 1'h0}, a);
         check(a, 1'h0, "select while busy");
         sbf_mst_i.sp();
         @(negedge sys_clk);
         write_done = 1'h1;
         @(negedge sys_clk);
         write_done = 1'h0;
         settle();
         check(busy, 1'h0, "busy after done");
      end
      $display("write test done");
   endtask
   // Model of the core side: predicted bytes, pulse counters and the run limit.
   always @(negedge sys_clk) begin
      cyc++;
      if (wr_byte.valid === 1'h1) begin
         if (exp_q.size() == 0) begin
            check(1'h1, 1'h0, "unwanted byte");
         end else begin
            check(wr_byte.data, exp_q.pop_front(), "written byte");
         end
      end
      if (write_start === 1'h1) ws_cnt++;
      if (rd_next === 1'h1) rn_cnt++;
      if (cyc == 30000) begin
         fail_count++;
         finish_test();
      end
   end
   initial begin
      seed = 32'hB7F2BDAC;
      {reset, wp, write_done, cs, rd_data} = {1'h1, 1'h0, 1'h0, 3'h0, 8'h00};
      repeat (10) @(posedge sys_clk);
      @(negedge sys_clk);
      reset = 1'h0;
      repeat (3) @(negedge sys_clk);
      check(standby, 1'h1, "standby");
      check(busy, 1'h0, "busy");
      // Every type field, with the chip-select field set to match on the half of the passes with t[4] set.
      for (t = 0; t < 32; t++) begin
         @(negedge sys_clk);
         cs = 3'($random(seed));
         b = {4'(t), t[4] ? cs : 3'($random(seed)), 1'h0};
         sbf_mst_i.st();
         sbf_mst_i.wb(b, a);
         check(a, b[7:1] == {`SBF_TYPE_ID, cs}, "select");
         sbf_mst_i.sp();
         settle();
         check(standby, 1'h1, "standby after stop");
      end
      $display("select test done");
      wr_txn(1, 1'h0);
      wr_txn(33, 1'h0);
      @(negedge sys_clk);
      wp = 1'h1;
      wr_txn(2, 1'h1);
      // Sequential read with protection on, ended by a refused acknowledge.
      rd_data = 8'($random(seed));
      t = rn_cnt;
      sel(1'h1);
      sbf_mst_i.rb(1'h1, b);
      check(b, rd_data, "read byte");
      sbf_mst_i.rb(1'h0, b);
      check(b, rd_data, "last byte");
      sbf_mst_i.sp();
      settle();
      check(rn_cnt - t, 1, "read advances");
      check(standby, 1'h1, "standby after read");
      // Random read: address-only write, repeated start, read select.
      rd_data = 8'($random(seed));
      sel(1'h0);
      sbf_mst_i.wb(8'h12, a);
      check(a, 1'h1, "addr ack");
      sbf_mst_i.wb(8'h34, a);
      check(a, 1'h1, "addr ack");
      check(addr_out, 16'h1234, "random address");
      sel(1'h1);
      sbf_mst_i.rb(1'h0, b);
      check(b, rd_data, "random byte");
      sbf_mst_i.sp();
      settle();
      check(standby, 1'h1, "standby after random read");
      $display("read test done");
      // A start two bits into a byte restarts select reception.
      sbf_mst_i.st();
      sbf_mst_i.bs(1'h1, a);
      sbf_mst_i.bs(1'h0, a);
      sel(1'h0);
      sbf_mst_i.sp();
      settle();
      $display("restart test done");
      finish_test();
   end
endmodule
`default_nettype wire
